//--- ctj_seq.sv
// Test sequencing, judgment and register file of the continuity tester
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Resistance lower limit 0.001..1.200 ohm, or 0.600 on high variant
// - Lower above upper with low check on: blink order error, no start
// - Voltage lower limit 0.01..5.40 V in 0.01 V steps
// - Timer on: PASS and finish when duration elapses within limits
// - Timer off: test runs until FAIL or stop
// - Duration 0.3..999 s, 0.1 s steps to 99.9, 1 s above
// - Offset on: stored offset subtracted before display and judgment
// - Offset run latches value on stop or expiry, back to ready
// - Current times upper limit over 5.4 V blocks start, blinks error
// - Settings over rated output block start, blink power error
// - No test start while in protection
// - No start while panel or remote stop asserted
// - Double action: start only within half second after stop
// - Momentary: test only while START held, release acts as stop
// - START in ready enters testing, shows testing, lights lamp
// - Time counts down with timer, up without; blinking 999 above
// - Test ends on expiry, out-of-limit, stop or protection
// - Low check on: between limits passes; off: below upper passes
// - FAIL shows down or up indication, fail lamp, buzzer
// - PASS shows indication, lamp, buzzer for hold time or forever
// - Stop with timer off gives no judgment, no pass
// - FAIL held with value and elapsed time until stop clears it
// - Method command toggles resistance/voltage basis of limits
// - Lower limit checking can be disabled, then ignored
module ctj_seq #(
  parameter int TICK_CYCLES = ctj_pkg::TICK_CYC,
  parameter int DA_CYCLES = ctj_pkg::DA_WIN_CYC,
  parameter int MAX_VA = ctj_pkg::MAX_VA_DEF,
  parameter logic [15:0] RES_MAX = ctj_pkg::RES_MAX_STD
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic start_sw_in,
  input wire logic stop_sw_in,
  input wire logic remote_stop_in,
  input wire logic protect_in,
  input wire logic meas_valid_in,
  input wire logic [15:0] meas_value_in,
  output ctj_pkg::ind_t ind_out,
  output logic output_on_out,
  output logic [15:0] time_disp_out,
  output logic [15:0] meas_disp_out
);
  import ctj_pkg::*;

  typedef struct packed {
    state_t st;
    logic start1, start2, start3;
    logic stop1, stop2;
    logic rem1, rem2;
    logic prot1, prot2;
    logic [7:0] ctrl;
    logic method_volt;
    logic [15:0] lower;
    logic [15:0] upper;
    logic [15:0] dur;
    logic [7:0] hold;
    logic [15:0] curr;
    logic [15:0] offset;
    logic [15:0] raw;
    logic [15:0] meas;
    logic [15:0] elapsed;
    logic [7:0] hold_cnt;
    logic [CNT_W-1:0] tcnt;
    logic [CNT_W-1:0] dwin;
    logic blink;
    logic fail_lo;
    logic fail_hi;
    logic [31:0] prd;
  } st_t;

  st_t s, n;
  logic tick, start_edge, stop_any, stop_req, expired;
  logic order_err, volt_err, pow_err, start_ok;
  logic low_bad, high_bad, fail_now;
  logic [15:0] corr, lim_max;
  logic [31:0] vprod;
  logic [47:0] pprod;
  logic [31:0] rdata;
  logic mapped, wr_acc;

  // Clamp a written value into its legal range
  function automatic logic [15:0] clampv(input logic [15:0] v,
      input logic [15:0] lo, input logic [15:0] hi);
    clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Derived conditions from settings and synchronised pins
  always_comb begin
    tick = (s.tcnt == CNT_W'(TICK_CYCLES - 1));
    start_edge = s.start2 & ~s.start3;
    stop_any = s.stop2 | s.rem2;
    // Momentary release counts as a stop while running
    stop_req = stop_any | (s.ctrl[CB_MOM] & ~s.start2);
    expired = s.ctrl[CB_TIMER] && (s.elapsed >= s.dur);
    lim_max = s.method_volt ? VOLT_MAX : RES_MAX;
    order_err = s.ctrl[CB_LOW] && (s.lower > s.upper);
    vprod = s.curr * s.upper;
    // Only resistance limits imply a voltage at the output
    volt_err = ~s.method_volt && (vprod > VOLT_LIM);
    pprod = {16'h0000, vprod} * {32'h0, s.curr};
    if (s.method_volt) begin
      pow_err = vprod > 32'(MAX_VA * 1000);
    end else begin
      pow_err = pprod > 48'(MAX_VA * 100000);
    end
    // Saturate so a large offset never wraps the reading
    if (s.ctrl[CB_OFFS]) begin
      corr = (meas_value_in > s.offset) ?
             16'(meas_value_in - s.offset) : 16'h0000;
    end else begin
      corr = meas_value_in;
    end
    low_bad = s.ctrl[CB_LOW] && (corr < s.lower);
    high_bad = corr > s.upper;
    fail_now = meas_valid_in && (low_bad || high_bad);
    start_ok = start_edge && ~s.prot2 && ~stop_any
             && ~order_err && ~volt_err && ~pow_err
             && (~s.ctrl[CB_DBL] || (s.dwin != '0));
  end

  // APB decode; reads are captured in the setup cycle
  always_comb begin
    mapped = 1'b1;
    rdata = 32'h0000_0000;
    unique case (paddr_in)
      OFS_CTRL: rdata = {23'h0, s.method_volt, s.ctrl};
      OFS_LOWER: rdata = {16'h0, s.lower};
      OFS_UPPER: rdata = {16'h0, s.upper};
      OFS_TIME: rdata = {16'h0, s.dur};
      OFS_HOLD: rdata = {24'h0, s.hold};
      OFS_CURR: rdata = {16'h0, s.curr};
      OFS_CMD: rdata = 32'h0000_0000;
      OFS_STAT: rdata = {20'h0, s.prot2, pow_err, volt_err,
                         order_err, s.fail_hi, s.fail_lo,
                         s.dwin != '0, s.st};
      OFS_MEAS: rdata = {16'h0, s.meas};
      OFS_TDISP: rdata = {16'h0, time_disp_out};
      OFS_OFFSET: rdata = {16'h0, s.offset};
      default: mapped = 1'b0;
    endcase
    wr_acc = psel_in & penable_in & pwrite_in & mapped;
  end

  assign pready_out = ce_in;
  assign pslverr_out = psel_in & penable_in & ~mapped;
  assign prdata_out = s.prd;

  // Next state of the whole block
  always_comb begin
    n = s;
    n.start1 = start_sw_in;
    n.start2 = s.start1;
    n.start3 = s.start2;
    n.stop1 = stop_sw_in;
    n.stop2 = s.stop1;
    n.rem1 = remote_stop_in;
    n.rem2 = s.rem1;
    n.prot1 = protect_in;
    n.prot2 = s.prot1;
    if (psel_in && !penable_in) begin
      n.prd = rdata;
    end
    // Register writes take effect in the access phase
    if (wr_acc) begin
      unique case (paddr_in)
        OFS_CTRL: n.ctrl = {1'b0, pwdata_in[6:0]};
        OFS_LOWER: n.lower = clampv(pwdata_in[15:0], LIM_MIN,
                                    lim_max);
        OFS_UPPER: n.upper = clampv(pwdata_in[15:0], LIM_MIN, lim_max);
        OFS_TIME: begin
          n.dur = clampv(pwdata_in[15:0], DUR_MIN, DUR_MAX);
          if (n.dur > DUR_FINE_TOP) begin
            n.dur = 16'(n.dur - (n.dur % 16'd10));
          end
        end
        OFS_HOLD: begin
          if (pwdata_in[7:0] < HOLD_MIN) begin
            n.hold = HOLD_MIN;
          end else if (pwdata_in[7:0] > HOLD_MAX) begin
            n.hold = HOLD_MAX;
          end else begin
            n.hold = pwdata_in[7:0];
          end
        end
        OFS_CURR: n.curr = pwdata_in[15:0];
        OFS_CMD: begin
          if (pwdata_in[0]) begin
            n.method_volt = ~s.method_volt;
          end
        end
        default: n.ctrl = s.ctrl;
      endcase
    end
    // Start window reloads while stop held, runs down after release
    if (stop_any) begin
      n.dwin = CNT_W'(DA_CYCLES);
    end else if (s.dwin != '0) begin
      n.dwin = s.dwin - 1'b1;
    end
    // 0.1 s time base; also drives the blink phase
    n.tcnt = tick ? '0 : s.tcnt + 1'b1;
    if (tick) begin
      n.blink = ~s.blink;
    end
    // Sequencer
    unique case (s.st)
      ST_READY: begin
        if (start_ok) begin
          n.st = s.ctrl[CB_OFFRUN] ? ST_OFFS : ST_TEST;
          n.elapsed = 16'h0000;
          n.tcnt = '0;
          n.fail_lo = 1'b0;
          n.fail_hi = 1'b0;
        end
      end
      ST_TEST: begin
        if (meas_valid_in) begin
          n.meas = corr;
        end
        if (tick && s.elapsed != 16'hFFFF) begin
          n.elapsed = s.elapsed + 1'b1;
        end
        // Stop outranks both judgments in the same cycle
        if (stop_req || s.prot2) begin
          n.st = ST_READY;
        end else if (fail_now) begin
          n.st = ST_FAIL;
          n.fail_lo = low_bad;
          n.fail_hi = high_bad & ~low_bad;
          n.elapsed = s.elapsed;
        end else if (expired) begin
          n.st = ST_PASS;
          n.hold_cnt = 8'h00;
        end
      end
      ST_PASS: begin
        if (tick && s.hold_cnt != 8'hFF) begin
          n.hold_cnt = s.hold_cnt + 1'b1;
        end
        if (stop_any || (!s.ctrl[CB_HOLDINF]
            && s.hold_cnt >= s.hold)) begin
          n.st = ST_READY;
        end
      end
      ST_FAIL: begin
        if (stop_any) begin
          n.st = ST_READY;
          n.fail_lo = 1'b0;
          n.fail_hi = 1'b0;
        end
      end
      ST_OFFS: begin
        if (meas_valid_in) begin
          n.raw = meas_value_in;
        end
        if (tick && s.elapsed != 16'hFFFF) begin
          n.elapsed = s.elapsed + 1'b1;
        end
        if (s.prot2) begin
          n.st = ST_READY;
        end else if (stop_req || expired) begin
          n.offset = s.raw;
          n.st = ST_READY;
        end
      end
      default: n.st = ST_READY;
    endcase
  end

  // Single state register, frozen while the clock enable is low
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      s <= '0;
      s.st <= ST_READY;
      s.ctrl <= CTRL_RST;
      s.lower <= LOWER_RST;
      s.upper <= UPPER_RST;
      s.dur <= TIME_RST;
      s.hold <= HOLD_RST;
      s.curr <= CURR_RST;
    end else if (ce_in) begin
      s <= n;
    end
  end

  // Time display: remaining with timer, elapsed otherwise or on FAIL
  always_comb begin
    if (s.st == ST_TEST && s.ctrl[CB_TIMER]) begin
      time_disp_out = (s.dur > s.elapsed) ?
                      16'(s.dur - s.elapsed) : 16'h0000;
    end else if (s.elapsed > DISP_MAX) begin
      time_disp_out = DISP_MAX;
    end else begin
      time_disp_out = s.elapsed;
    end
  end

  // Indicators decoded from registered state
  always_comb begin
    ind_out.order_err = order_err & s.blink;
    ind_out.voltage_range_error = volt_err & s.blink;
    ind_out.power_range_error = pow_err & s.blink;
    ind_out.ready = (s.st == ST_READY) && !order_err && !volt_err
                    && !pow_err && !s.prot2
                    && (!s.ctrl[CB_DBL] || s.dwin != '0);
    ind_out.testing = (s.st == ST_TEST) || (s.st == ST_OFFS);
    ind_out.test_lamp = ind_out.testing;
    ind_out.pass_lamp = (s.st == ST_PASS);
    ind_out.fail_lamp = (s.st == ST_FAIL);
    ind_out.buzzer = ind_out.pass_lamp | ind_out.fail_lamp;
    ind_out.fail_down = ind_out.fail_lamp & s.fail_lo;
    ind_out.fail_up = ind_out.fail_lamp & s.fail_hi;
    ind_out.time_blink = (s.elapsed > DISP_MAX) & s.blink
                         & !(s.st == ST_TEST && s.ctrl[CB_TIMER]);
  end

  assign output_on_out = ind_out.testing;
  assign meas_disp_out = s.meas;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in || !ce_in);

  sequence q_idle_press;
    s.st == ST_READY && start_edge;
  endsequence
  sequence q_running;
    s.st == ST_TEST && !s.prot2;
  endsequence

  a_prot_blocks: assert property (
    q_idle_press and s.prot2 |=> s.st == ST_READY)
    else $error("start taken during protection");
  a_order_blocks: assert property (
    q_idle_press and order_err |=> s.st == ST_READY)
    else $error("start taken with limit order error");
  a_volt_blocks: assert property (
    q_idle_press and volt_err |=> !ind_out.testing)
    else $error("start taken with voltage range error");
  a_power_blocks: assert property (
    q_idle_press and pow_err |=> !ind_out.testing)
    else $error("start taken with power range error");
  a_stop_blocks: assert property (
    q_idle_press and stop_any |=> s.st == ST_READY)
    else $error("start taken while stop asserted");
  a_stop_wins: assert property (
    q_running and stop_any and expired |=> s.st == ST_READY)
    else $error("expiry beat a stop request");
  a_fail_held: assert property (
    s.st == ST_FAIL && !stop_any |=> s.st == ST_FAIL
                                  && $stable(s.elapsed))
    else $error("fail result not held");
  a_pass_on_expiry: assert property (
    q_running and !stop_req and !fail_now and expired
    |=> ind_out.pass_lamp ##1 ind_out.buzzer)
    else $error("no pass after duration");
  a_fail_sample: assert property (
    q_running and !stop_req and meas_valid_in and high_bad
    and !low_bad |=> ind_out.fail_up && !ind_out.fail_down)
    else $error("out of limit sample not failed");
  a_momentary_rel: assert property (
    q_running and s.ctrl[CB_MOM] and !s.start2 |=> !ind_out.testing)
    else $error("test kept running after release");
  a_dbl_window: assert property (
    q_idle_press and s.ctrl[CB_DBL] and s.dwin == '0
    |=> s.st == ST_READY)
    else $error("start outside double action window");
endmodule
`default_nettype wire

//--- ctj_pkg.sv
// Constants and carrier types of the continuity test sequencer
`default_nettype none
package ctj_pkg;
  // Time base: 100 MHz clock, 0.1 s timer step, 0.5 s start window
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 100_000_000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int DA_WIN_NS = 500_000_000;
  localparam int DA_WIN_CYC = DA_WIN_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 27;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LOWER = 8'h04;
  localparam logic [7:0] OFS_UPPER = 8'h08;
  localparam logic [7:0] OFS_TIME = 8'h0C;
  localparam logic [7:0] OFS_HOLD = 8'h10;
  localparam logic [7:0] OFS_CURR = 8'h14;
  localparam logic [7:0] OFS_CMD = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;
  localparam logic [7:0] OFS_MEAS = 8'h20;
  localparam logic [7:0] OFS_TDISP = 8'h24;
  localparam logic [7:0] OFS_OFFSET = 8'h28;
  // Control register bit positions
  localparam int CB_TIMER = 0;
  localparam int CB_LOW = 1;
  localparam int CB_OFFS = 2;
  localparam int CB_MOM = 3;
  localparam int CB_DBL = 4;
  localparam int CB_HOLDINF = 5;
  localparam int CB_OFFRUN = 6;
  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [15:0] LOWER_RST = 16'h0001;
  localparam logic [15:0] UPPER_RST = 16'h0064;
  localparam logic [15:0] TIME_RST = 16'h001E;
  localparam logic [7:0] HOLD_RST = 8'h02;
  localparam logic [15:0] CURR_RST = 16'h00FA;
  // Setting ranges (mohm, 10 mV, 0.1 s units)
  localparam logic [15:0] LIM_MIN = 16'h0001;
  localparam logic [15:0] RES_MAX_STD = 16'h04B0;
  localparam logic [15:0] RES_MAX_HI = 16'h0258;
  localparam logic [15:0] VOLT_MAX = 16'h021C;
  localparam logic [15:0] DUR_MIN = 16'h0003;
  localparam logic [15:0] DUR_MAX = 16'h2706;
  localparam logic [15:0] DUR_FINE_TOP = 16'h03E7;
  localparam logic [7:0] HOLD_MIN = 8'h02;
  localparam logic [7:0] HOLD_MAX = 8'h64;
  localparam logic [15:0] DISP_MAX = 16'h2706;
  // Test current times upper limit, in 0.1 mV, for 5.4 V
  localparam logic [31:0] VOLT_LIM = 32'h0000D2F0;
  localparam int MAX_VA_DEF = 500;

  typedef enum logic [4:0] {
    ST_READY = 5'b00001,
    ST_TEST = 5'b00010,
    ST_PASS = 5'b00100,
    ST_FAIL = 5'b01000,
    ST_OFFS = 5'b10000
  } state_t;

  typedef struct packed {
    logic ready;
    logic testing;
    logic test_lamp;
    logic pass_lamp;
    logic fail_lamp;
    logic buzzer;
    logic fail_down;
    logic fail_up;
    logic order_err;
    logic voltage_range_error;
    logic power_range_error;
    logic time_blink;
  } ind_t;
endpackage
`default_nettype wire

//--- ctj_panel_model.sv
// Front-panel switch and remote stop model facing the sequencer pins
`timescale 1ns/10ps
`default_nettype none
module ctj_panel_model (
  output logic start_sw_out,
  output logic stop_sw_out,
  output logic remote_stop_out,
  output logic protect_out
);
  // Switches always driven, released at power-up
  initial begin
    start_sw_out = 1'b0;
    stop_sw_out = 1'b0;
    remote_stop_out = 1'b0;
    protect_out = 1'b0;
  end
  // Levels move only right after a clock edge, so no race with sampling
  task set_start(input logic v);
    start_sw_out <= v;
  endtask
  task set_stop(input logic v);
    stop_sw_out <= v;
  endtask
  task set_remote(input logic v);
    remote_stop_out <= v;
  endtask
  task set_protect(input logic v);
    protect_out <= v;
  endtask
endmodule
`default_nettype wire

//--- test_ctj_seq.sv
// Self-checking bench for the continuity test sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  miscompares++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module test_ctj_seq;
  import ctj_pkg::*;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, mvld, out_on;
  logic st_sw, sp_sw, rm_sw, pr_sw, e, ce;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] mv, tdisp, mdisp, t0;
  ind_t ind;
  int miscompares = 0;
  int n_compared = 0;
  int n;
  // Short tick and window so the run stays brief
  always #5 mclk_in = ~mclk_in;
  ctj_seq #(.TICK_CYCLES(10), .DA_CYCLES(30)) dut_u (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .ce_in(ce),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .start_sw_in(st_sw),
    .stop_sw_in(sp_sw), .remote_stop_in(rm_sw), .protect_in(pr_sw),
    .meas_valid_in(mvld), .meas_value_in(mv), .ind_out(ind),
    .output_on_out(out_on), .time_disp_out(tdisp), .meas_disp_out(mdisp));
  ctj_panel_model pan_u (
    .start_sw_out(st_sw), .stop_sw_out(sp_sw),
    .remote_stop_out(rm_sw), .protect_out(pr_sw));
  task results();
    $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge mclk_in);
  endtask
  // One APB transfer; waits for pready under a bound
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk_in);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      results();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_in);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    `CHK("register", ex, r)
  endtask
  // One-cycle sample pulse, then room for the verdict to show
  task samp(input logic [15:0] v);
    mv <= v;
    mvld <= 1'b1;
    cyc(1);
    mvld <= 1'b0;
    cyc(2);
  endtask
  task go();
    pan_u.set_start(1'b1);
    cyc(6);
  endtask
  task halt();
    pan_u.set_start(1'b0);
    pan_u.set_stop(1'b1);
    cyc(6);
    pan_u.set_stop(1'b0);
    cyc(1);
  endtask
  task wait_lamp(input logic lvl);
    n = 0;
    while (ind.pass_lamp !== lvl && n < 100) begin
      cyc(1);
      n++;
    end
    if (ind.pass_lamp !== lvl) begin
      miscompares++;
      results();
    end
  endtask
  initial begin
    {psel, penable, pwrite, mvld} = 4'h0;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    mv = 16'h0000;
    cyc(2);
    reset_n_in <= 1'b1;
    cyc(1);
    // Reset values and an unmapped place
    rchk(OFS_CTRL, 32'(CTRL_RST));
    rchk(OFS_UPPER, 32'(UPPER_RST));
    rchk(OFS_TIME, 32'(TIME_RST));
    rchk(OFS_HOLD, 32'(HOLD_RST));
    rchk(OFS_CURR, 32'(CURR_RST));
    apb(1'b1, 8'h3C, 32'h5);
    `CHK("slverr", 1'b1, e)
    rchk(8'h3C, 32'h0);
    // Setting ranges at both ends
    apb(1'b1, OFS_LOWER, 32'h0);
    rchk(OFS_LOWER, 32'h1);
    apb(1'b1, OFS_LOWER, 32'hFFF);
    rchk(OFS_LOWER, 32'(RES_MAX_STD));
    apb(1'b1, OFS_TIME, 32'h2);
    rchk(OFS_TIME, 32'(DUR_MIN));
    apb(1'b1, OFS_TIME, 32'h3ED);
    rchk(OFS_TIME, 32'h3E8);
    apb(1'b1, OFS_TIME, 32'hFFFF);
    rchk(OFS_TIME, 32'(DUR_MAX));
    // Timed pass with low check off and a low sample
    apb(1'b1, OFS_TIME, 32'h3);
    apb(1'b1, OFS_LOWER, 32'h14);
    go();
    `CHK("testing", 1'b1, ind.testing)
    `CHK("test lamp", 1'b1, ind.test_lamp)
    t0 = tdisp;
    `CHK("count start", 16'h3, t0)
    cyc(10);
    `CHK("countdown", t0 - 16'h1, tdisp)
    samp(16'h5);
    pan_u.set_start(1'b0);
    wait_lamp(1'b1);
    `CHK("buzzer", 1'b1, ind.buzzer)
    `CHK("ended", 1'b0, ind.testing)
    wait_lamp(1'b0);
    `CHK("hold", 1'b1, n >= 19 && n <= 32)
    `CHK("ready", 1'b1, ind.ready)
    // Remote stop lands in the very cycle the timer expires
    go();
    cyc(25);
    pan_u.set_remote(1'b1);
    cyc(4);
    `CHK("stop wins", 1'b0, ind.pass_lamp)
    `CHK("stop end", 1'b0, ind.testing)
    pan_u.set_start(1'b0);
    pan_u.set_remote(1'b0);
    // Untimed run ended by a high sample
    apb(1'b1, OFS_CTRL, 32'h0);
    go();
    samp(16'h64);
    t0 = tdisp;
    `CHK("count base", 16'h0, t0)
    // Clock enable low freezes the run, time base included
    ce <= 1'b0;
    cyc(30);
    `CHK("frozen", t0, tdisp)
    `CHK("no ready", 1'b0, pready)
    ce <= 1'b1;
    cyc(20);
    `CHK("count up", t0 + 16'h2, tdisp)
    `CHK("running", 1'b1, ind.testing)
    samp(16'h65);
    `CHK("fail up", 1'b1, ind.fail_up)
    `CHK("fail lamp", 1'b1, ind.fail_lamp)
    `CHK("fail buzz", 1'b1, ind.buzzer)
    `CHK("not down", 1'b0, ind.fail_down)
    `CHK("value", 16'h65, mdisp)
    cyc(40);
    `CHK("held", 1'b1, ind.fail_lamp)
    halt();
    `CHK("cleared", 1'b1, ind.ready)
    // Low check on, sample under the lower limit
    apb(1'b1, OFS_CTRL, 32'h2);
    go();
    samp(16'h14);
    samp(16'h13);
    `CHK("fail down", 1'b1, ind.fail_down)
    halt();
    // Stop without timer gives no verdict
    apb(1'b1, OFS_CTRL, 32'h0);
    go();
    halt();
    `CHK("no pass", 1'b0, ind.pass_lamp)
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK("state", 5'h01, r[4:0])
    // Limit order error blocks start
    apb(1'b1, OFS_CTRL, 32'h2);
    apb(1'b1, OFS_LOWER, 32'h96);
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK("order", 1'b1, r[8])
    go();
    `CHK("order start", 1'b0, ind.testing)
    `CHK("order ready", 1'b0, ind.ready)
    e = ind.order_err;
    cyc(10);
    `CHK("order blink", ~e, ind.order_err)
    pan_u.set_start(1'b0);
    apb(1'b1, OFS_LOWER, 32'h14);
    // Protection: blocks start, ends a running test
    pan_u.set_protect(1'b1);
    cyc(4);
    go();
    `CHK("prot start", 1'b0, ind.testing)
    pan_u.set_start(1'b0);
    pan_u.set_protect(1'b0);
    cyc(4);
    go();
    pan_u.set_protect(1'b1);
    cyc(6);
    `CHK("prot end", 1'b0, ind.testing)
    `CHK("prot fail", 1'b0, ind.fail_lamp)
    pan_u.set_start(1'b0);
    pan_u.set_protect(1'b0);
    // Remote stop held blocks start
    pan_u.set_remote(1'b1);
    cyc(4);
    go();
    `CHK("remote", 1'b0, ind.testing)
    pan_u.set_start(1'b0);
    pan_u.set_remote(1'b0);
    // Output voltage range, just over and at the edge
    apb(1'b1, OFS_UPPER, 32'hD9);
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK("volt err", 1'b1, r[9])
    go();
    `CHK("volt start", 1'b0, ind.testing)
    e = ind.voltage_range_error;
    cyc(10);
    `CHK("volt blink", ~e, ind.voltage_range_error)
    pan_u.set_start(1'b0);
    apb(1'b1, OFS_UPPER, 32'hD8);
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK("volt edge", 1'b0, r[9])
    // Voltage basis, its clamps and the power limit
    apb(1'b1, OFS_CMD, 32'h1);
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK("method", 1'b1, r[8])
    apb(1'b1, OFS_UPPER, 32'h3E8);
    rchk(OFS_UPPER, 32'(VOLT_MAX));
    apb(1'b1, OFS_LOWER, 32'h3E8);
    rchk(OFS_LOWER, 32'(VOLT_MAX));
    apb(1'b1, OFS_CURR, 32'h3E8);
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK("pow err", 1'b1, r[10])
    go();
    `CHK("pow start", 1'b0, ind.testing)
    e = ind.power_range_error;
    cyc(10);
    `CHK("pow blink", ~e, ind.power_range_error)
    pan_u.set_start(1'b0);
    apb(1'b1, OFS_CURR, 32'h39D);
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK("pow edge", 1'b0, r[10])
    apb(1'b1, OFS_CURR, 32'hFA);
    apb(1'b1, OFS_LOWER, 32'h14);
    apb(1'b1, OFS_CMD, 32'h1);
    apb(1'b1, OFS_UPPER, 32'h64);
    // Hold-to-run: release ends the test
    apb(1'b1, OFS_CTRL, 32'h8);
    go();
    `CHK("mom run", 1'b1, ind.testing)
    pan_u.set_start(1'b0);
    cyc(6);
    `CHK("mom stop", 1'b0, ind.testing)
    // Two-step start: late refused, prompt accepted
    apb(1'b1, OFS_CTRL, 32'h10);
    cyc(40);
    go();
    `CHK("da late", 1'b0, ind.testing)
    halt();
    go();
    `CHK("da prompt", 1'b1, ind.testing)
    halt();
    cyc(50);
    go();
    `CHK("da expired", 1'b0, ind.testing)
    pan_u.set_start(1'b0);
    // Offset capture, then subtraction in display and judgment
    apb(1'b1, OFS_CTRL, 32'h40);
    go();
    `CHK("offs run", 1'b1, out_on)
    samp(16'h1E);
    halt();
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK("offs ready", 5'h01, r[4:0])
    rchk(OFS_OFFSET, 32'h1E);
    apb(1'b1, OFS_CTRL, 32'h4);
    go();
    samp(16'h50);
    `CHK("corrected", 16'h32, mdisp)
    samp(16'h82);
    `CHK("offs pass", 1'b0, ind.fail_lamp)
    samp(16'h83);
    `CHK("offs fail", 1'b1, ind.fail_up)
    halt();
    results();
  end
endmodule
`default_nettype wire
